// ===== tb/crc16_ccitt_byte_engine_props.sv
// Port-level concurrent checks for the CRC16 byte engine
module crc16_engine_props
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// Register port
	input wire logic [2:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        wr_ready_o,
	// Power requests and status
	input wire logic        stop_light_i,
	input wire logic        stop_deep_i,
	input wire logic [15:0] crc_o,
	input wire logic        standby_o,
	input wire logic        busy_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	read_high_a: assert property ($past(rd_i && !stop_deep_i
		&& addr_i == crc16_pkg::ADDR_HIGH) |-> rdata_o == crc_o[15:8])
		else $error("high byte read differs from remainder");
	read_low_a: assert property ($past(rd_i && !stop_deep_i
		&& addr_i == crc16_pkg::ADDR_LOW) |-> rdata_o == crc_o[7:0])
		else $error("low byte read differs from remainder");
	// Quiet bus must not disturb the remainder
	idle_hold_a: assert property (!busy_o && !wr_i && !$past(wr_i)
		&& !stop_deep_i |=> $stable(crc_o))
		else $error("remainder moved with no write");

	// ------------------------------------------------------------
	// Seed, queue and power modes
	// ------------------------------------------------------------
	seed_high_a: assert property ((wr_i && !busy_o && !stop_light_i
		&& addr_i == crc16_pkg::ADDR_HIGH && !stop_deep_i)
		##1 (!stop_light_i && !stop_deep_i)
		|=> crc_o[15:8] == $past(wdata_i, 2))
		else $error("high seed byte not loaded");
	ready_empty_a: assert property (!busy_o |-> wr_ready_o)
		else $error("empty queue refuses writes");
	deep_clear_a: assert property (stop_deep_i
		|=> crc_o == 16'h0000 && !busy_o && wr_ready_o)
		else $error("deep stop did not clear engine");
	standby_a: assert property (!stop_deep_i
		|=> standby_o == $past(stop_light_i))
		else $error("standby flag does not follow light stop");
	freeze_a: assert property (stop_light_i && standby_o
		&& !stop_deep_i |=> $stable(crc_o))
		else $error("remainder moved while frozen");
endmodule : crc16_engine_props

bind crc16_ccitt_byte_engine crc16_engine_props u_props
(
	.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.wr_ready_o, .stop_light_i, .stop_deep_i, .crc_o, .standby_o,
	.busy_o
);

// ===== tb/test_crc16_ccitt_byte_engine.sv
// Self-checking bench for the CRC16 byte engine
module test_crc16_ccitt_byte_engine;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and case table
	// ------------------------------------------------------------
	logic        clk_i;
	logic        rst_n_i;
	logic [2:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  rdata_o;
	logic        wr_ready_o;
	logic        stop_light_i;
	logic        stop_deep_i;
	logic [15:0] crc_o;
	logic        standby_o;
	logic        busy_o;
	int          n_fail;
	int          cmp_count;
	logic [15:0] exp_q;

	typedef struct
	{
		logic [15:0] seed;
		string       msg;
		logic [15:0] res;
	} row_t;
	row_t rows [4];

	crc16_ccitt_byte_engine dut
	(
		.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.wr_ready_o, .stop_light_i, .stop_deep_i, .crc_o, .standby_o,
		.busy_o
	);

	// Free-running 100 MHz clock
	initial
	begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Bitwise reference, MSB first, no augmentation or inversion
	function automatic logic [15:0] step(input logic [15:0] c,
		input logic [7:0] d);
		logic fb;
		for (int i = 7; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'h0} ^ (fb ? crc16_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction : step

	// The write strobe stays up until the next task, so a write may follow a write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'h1;
		rd_i    <= 1'h0;
		@(posedge clk_i);
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		addr_i <= a;
		wr_i   <= 1'h0;
		rd_i   <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		@(posedge clk_i);
		chk({8'h00, rdata_o}, {8'h00, e});
	endtask : rd

	task automatic idle(input int n);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
		repeat (n) @(posedge clk_i);
	endtask : idle

	// Read both bytes, then the status copy of the remainder
	task automatic rdcrc(input logic [15:0] e);
		rd(crc16_pkg::ADDR_HIGH, e[15:8]);
		rd(crc16_pkg::ADDR_LOW, e[7:0]);
		chk(crc_o, e);
	endtask : rdcrc

	task automatic drain();
		int k;
		k = 0;
		idle(2);
		while (busy_o !== 1'h0 && k < 40)
		begin
			@(posedge clk_i);
			k++;
		end
		if (busy_o !== 1'h0)
		begin
			n_fail++;
			summarize();
		end
	endtask : drain

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_n_i, wr_i, rd_i, stop_light_i, stop_deep_i} = 5'h00;
		addr_i    = 3'h0;
		wdata_i   = 8'h00;
		n_fail    = 0;
		cmp_count = 0;
		rows[0] = '{16'h0000, "A", 16'h58E5};
		rows[1] = '{16'hFFFF, "A", 16'hB915};
		rows[2] = '{16'h0000, "123456789", 16'h31C3};
		rows[3] = '{16'hFFFF, "123456789", 16'h29B1};
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'h1;
		idle(2);
		chk(crc_o, 16'h0000);
		chk({rdata_o, 5'h00, busy_o, standby_o, wr_ready_o}, 16'h0001);
		// No seed pending after reset: a low write is data
		wr(crc16_pkg::ADDR_LOW, 8'h41);
		rdcrc(16'h58E5);
		// Table cases, result read the cycle after the last byte
		foreach (rows[r])
		begin
			wr(crc16_pkg::ADDR_HIGH, rows[r].seed[15:8]);
			wr(crc16_pkg::ADDR_LOW, rows[r].seed[7:0]);
			for (int i = 0; i < rows[r].msg.len(); i++)
				wr(crc16_pkg::ADDR_LOW, rows[r].msg[i]);
			rdcrc(rows[r].res);
		end
		// Seed halves land without shifting, then one data byte
		wr(crc16_pkg::ADDR_HIGH, 8'hAB);
		wr(crc16_pkg::ADDR_LOW, 8'hCD);
		rdcrc(16'hABCD);
		wr(crc16_pkg::ADDR_LOW, 8'h5A);
		rdcrc(step(16'hABCD, 8'h5A));
		// Restart straight after data, back to back
		wr(crc16_pkg::ADDR_LOW, 8'h99);
		wr(crc16_pkg::ADDR_HIGH, 8'h12);
		wr(crc16_pkg::ADDR_LOW, 8'h34);
		wr(crc16_pkg::ADDR_LOW, 8'h00);
		exp_q = step(16'h1234, 8'h00);
		rdcrc(exp_q);
		// Unmapped place: write ignored, reads zero, remainder kept
		wr(3'h5, 8'hFF);
		rd(3'h5, 8'h00);
		rdcrc(exp_q);
		// Light stop: queue fills and refuses, remainder frozen
		// Byte count cleared first, so only the queued bytes count
		wr(crc16_pkg::ADDR_COUNT_LO, 8'h00);
		stop_light_i <= 1'h1;
		idle(2);
		for (int i = 0; i < 9; i++)
			wr(crc16_pkg::ADDR_LOW, 8'h10 + 8'(i));
		idle(2);
		chk({crc_o[7:0], 5'h00, busy_o, standby_o, wr_ready_o},
			{exp_q[7:0], 8'h06});
		stop_light_i <= 1'h0;
		drain();
		for (int i = 0; i < 8; i++)
			exp_q = step(exp_q, 8'h10 + 8'(i));
		rdcrc(exp_q);
		// Ninth write was refused: drop flag up, cleared by writing one
		rd(crc16_pkg::ADDR_STATUS, 8'h08);
		wr(crc16_pkg::ADDR_STATUS, 8'h08);
		rd(crc16_pkg::ADDR_STATUS, 8'h00);
		// Eight message bytes shifted since the clear
		rd(crc16_pkg::ADDR_COUNT_LO, 8'h08);
		rd(crc16_pkg::ADDR_COUNT_HI, 8'h00);
		// Deep stop with a seed pending: back in reset state
		wr(crc16_pkg::ADDR_HIGH, 8'h77);
		idle(2);
		stop_deep_i <= 1'h1;
		idle(2);
		stop_deep_i <= 1'h0;
		idle(2);
		chk(crc_o, 16'h0000);
		wr(crc16_pkg::ADDR_LOW, 8'h41);
		rdcrc(16'h58E5);
		// Reset in mid-run also drops a pending seed
		wr(crc16_pkg::ADDR_HIGH, 8'h77);
		idle(2);
		rst_n_i <= 1'h0;
		idle(2);
		rst_n_i <= 1'h1;
		idle(1);
		chk(crc_o, 16'h0000);
		wr(crc16_pkg::ADDR_LOW, 8'h41);
		rdcrc(16'h58E5);
		idle(2);
		summarize();
	end
endmodule : test_crc16_ccitt_byte_engine

// ===== verilog/crc16_byte_step.sv
// One byte of CRC16 shifting, most significant bit first
module crc16_byte_step
(
	// Current remainder and message byte
	input  wire logic [15:0] crc_i,
	input  wire logic [7:0]  data_i,
	// Remainder after eight shifts
	output logic      [15:0] crc_o
);

	logic [15:0] chain [0:8];

	assign chain[0] = crc_i;

	// ------------------------------------------------------------------
	// Serial feedback, one stage per message bit
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_bit
			logic fb;
			// Feedback is top bit xor incoming bit, no zero augmentation
			assign fb = chain[gi][15] ^ data_i[7 - gi];
			assign chain[gi + 1] = {chain[gi][14:0], 1'b0}
				^ (fb ? crc16_pkg::CRC_POLY : 16'h0000);
		end
	endgenerate

	// Remainder leaves uncomplemented
	assign crc_o = chain[8];

endmodule : crc16_byte_step

// ===== verilog/crc16_ccitt_byte_engine.sv
// CRC16 byte engine with seed loading, write queue and register port
//
// Behaviour
// - Remainder kept in a 16-bit shift register, x^16+x^12+x^5+1, serial feedback.
// - Feedback taps are the constant 0x1021.
// - High byte write loads bits 15-8 directly and arms seed pending.
// - Low byte write while pending loads bits 7-0, clears pending, no shift.
// - Low byte write without pending shifts eight bits in, MSB first.
// - Shifting of a byte completes by the next bus cycle.
// - Reads of high and low bytes return live remainder, no side effect.
// - No zero augmentation, remainder shown uncomplemented.
// - Seed may be any 16-bit value, including all zeros and all ones.
// - Wait mode leaves the engine running as in run mode.
// - Deep stop disables the engine; it returns in reset state.
// - Light stop freezes the calculation and resumes it unchanged.
// - High byte write, unless refused by a full queue, restarts the seed and abandons the remainder.
module crc16_ccitt_byte_engine
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// Write queue back-pressure
	output logic             wr_ready_o,
	// Power mode requests from the system
	input  wire logic        stop_light_i,
	input  wire logic        stop_deep_i,
	// Status
	output logic      [15:0] crc_o,
	output logic             standby_o,
	output logic             busy_o
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	crc16_pkg::eng_state_t state_q;
	crc16_pkg::eng_state_t state_d;

	logic        blk_rst_n;
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic [15:0] crc_step;
	logic        pending_q;
	logic        pending_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic        drop_q;
	logic        ready_q;
	logic [7:0]  rdata_q;
	logic        standby_q;
	logic        busy_q;

	logic        hit_high;
	logic        hit_low;
	logic        hit_status;
	logic        hit_count;
	logic        push_req;
	logic        push;
	logic        drop_evt;

	logic [8:0]  in_entry;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [8:0]  fifo_out_data;
	logic        fifo_out_ready;
	logic [3:0]  fifo_level;
	logic        pop;
	logic        pop_is_high;
	logic [7:0]  pop_byte;
	logic [3:0]  level_next;
	logic [7:0]  status_byte;

	// ------------------------------------------------------------------
	// Block reset
	// ------------------------------------------------------------------

	// Deep stop holds the datapath cleared, but not the power state or standby flag, so recovery is a reset
	assign blk_rst_n = rst_n_i && !stop_deep_i;

	// ------------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------------

	// Wait mode needs no input: the engine simply keeps running
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			crc16_pkg::ENG_RUN:
			begin
				if (stop_deep_i)
					state_d = crc16_pkg::ENG_OFF;
				else if (stop_light_i)
					state_d = crc16_pkg::ENG_STANDBY;
			end
			crc16_pkg::ENG_STANDBY:
			begin
				if (stop_deep_i)
					state_d = crc16_pkg::ENG_OFF;
				else if (!stop_light_i)
					state_d = crc16_pkg::ENG_RUN;
			end
			crc16_pkg::ENG_OFF:
			begin
				// Leaving deep stop into a held light stop freezes at once
				if (!stop_deep_i && stop_light_i)
					state_d = crc16_pkg::ENG_STANDBY;
				else if (!stop_deep_i)
					state_d = crc16_pkg::ENG_RUN;
			end
			default:
			begin
				state_d = crc16_pkg::ENG_RUN;
			end
		endcase
	end

	// State register; plain reset returns to run
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			state_q <= crc16_pkg::ENG_RUN;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	assign hit_high   = (addr_i == crc16_pkg::ADDR_HIGH);
	assign hit_low    = (addr_i == crc16_pkg::ADDR_LOW);
	assign hit_status = (addr_i == crc16_pkg::ADDR_STATUS);
	assign hit_count  = (addr_i == crc16_pkg::ADDR_COUNT_LO)
		|| (addr_i == crc16_pkg::ADDR_COUNT_HI);

	// ------------------------------------------------------------------
	// Write queue
	// ------------------------------------------------------------------

	// Both byte writes are queued with a kind tag so that seed and data
	// keep their order even when the engine is frozen
	assign push_req = wr_i && (hit_high || hit_low);
	assign push     = push_req && fifo_in_ready;
	assign drop_evt = push_req && !fifo_in_ready;
	assign in_entry = {hit_high, wdata_i};

	// The engine drains only while running
	assign fifo_out_ready = (state_q == crc16_pkg::ENG_RUN);
	assign pop            = fifo_out_valid && fifo_out_ready;
	assign pop_is_high    = fifo_out_data[crc16_pkg::ENTRY_KIND];
	assign pop_byte       = fifo_out_data[7:0];

	crc16_entry_fifo
	#(
		.WIDTH (crc16_pkg::ENTRY_W),
		.DEPTH (crc16_pkg::FIFO_DEPTH)
	)
	u_fifo
	(
		.clk_i       (clk_i),
		.rst_n_i     (blk_rst_n),
		.in_valid_i  (push_req),
		.in_data_i   (in_entry),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (fifo_out_data),
		.out_ready_i (fifo_out_ready),
		.level_o     (fifo_level)
	);

	// Level one edge ahead, so ready can come from a flop
	always_comb
	begin
		level_next = fifo_level;
		if (push && !pop)
			level_next = fifo_level + 4'h1;
		else if (pop && !push)
			level_next = fifo_level - 4'h1;
	end

	// Registered ready for the writer
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			ready_q <= 1'b1;
		else
			ready_q <= (level_next != crc16_pkg::FIFO_DEPTH[3:0]);
	end

	// ------------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------------

	// Eight serial stages unrolled into one cycle
	crc16_byte_step u_step
	(
		.crc_i  (crc_q),
		.data_i (pop_byte),
		.crc_o  (crc_step)
	);

	// Next remainder and seed state for the entry being drained
	always_comb
	begin
		crc_d     = crc_q;
		pending_d = pending_q;
		if (pop)
		begin
			if (pop_is_high)
			begin
				// Restart: high seed byte lands without shifting
				crc_d[15:8] = pop_byte;
				pending_d   = 1'b1;
			end
			else if (pending_q)
			begin
				// Seed completes, still no shifting
				crc_d[7:0] = pop_byte;
				pending_d  = 1'b0;
			end
			else
			begin
				// Message byte, whole byte in this cycle
				crc_d = crc_step;
			end
		end
	end

	// Remainder register
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			crc_q <= crc16_pkg::CRC_RESET;
		else
			crc_q <= crc_d;
	end

	// Seed pending flag
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			pending_q <= crc16_pkg::PENDING_RESET;
		else
			pending_q <= pending_d;
	end

	// ------------------------------------------------------------------
	// Byte counter
	// ------------------------------------------------------------------

	// Counts message bytes since the last clear; a byte in the clearing cycle restarts the count at one
	always_comb
	begin
		count_d = count_q;
		if (wr_i && hit_count)
			count_d = crc16_pkg::COUNT_RESET;
		if (pop && !pop_is_high && !pending_q)
			count_d = (wr_i && hit_count) ? 16'h0001 : count_q + 16'h0001;
	end

	// Counter register
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			count_q <= crc16_pkg::COUNT_RESET;
		else
			count_q <= count_d;
	end

	// ------------------------------------------------------------------
	// Dropped write flag
	// ------------------------------------------------------------------

	// Sticky; a drop in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			drop_q <= crc16_pkg::DROP_RESET;
		else if (drop_evt)
			drop_q <= 1'b1;
		else if (wr_i && hit_status && wdata_i[crc16_pkg::ST_DROP])
			drop_q <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------

	// Status byte assembled from live state
	always_comb
	begin
		status_byte = 8'h00;
		status_byte[crc16_pkg::ST_PENDING] = pending_d;
		status_byte[crc16_pkg::ST_BUSY]    = (level_next != 4'h0);
		status_byte[crc16_pkg::ST_STANDBY] = (state_q == crc16_pkg::ENG_STANDBY);
		status_byte[crc16_pkg::ST_DROP]    = drop_q;
		status_byte[crc16_pkg::ST_LEVEL_LSB +: 4] = level_next;
	end

	// Reads sample the remainder including this cycle's update, so a
	// read one cycle after a data write already sees the new value;
	// data stand for exactly one cycle
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			rdata_q <= crc16_pkg::RDATA_RESET;
		else if (rd_i)
		begin
			case (addr_i)
				crc16_pkg::ADDR_HIGH:     rdata_q <= crc_d[15:8];
				crc16_pkg::ADDR_LOW:      rdata_q <= crc_d[7:0];
				crc16_pkg::ADDR_STATUS:   rdata_q <= status_byte;
				crc16_pkg::ADDR_COUNT_LO: rdata_q <= count_d[7:0];
				crc16_pkg::ADDR_COUNT_HI: rdata_q <= count_d[15:8];
				default:                  rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= crc16_pkg::RDATA_RESET;
	end

	// ------------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------------

	// Standby indicator
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			standby_q <= 1'b0;
		else
			standby_q <= (state_d == crc16_pkg::ENG_STANDBY);
	end

	// Busy while queued entries remain after this edge
	always_ff @(posedge clk_i)
	begin
		if (!blk_rst_n)
			busy_q <= 1'b0;
		else
			busy_q <= (level_next != 4'h0);
	end

	// Outputs straight from flops
	assign rdata_o    = rdata_q;
	assign wr_ready_o = ready_q;
	assign crc_o      = crc_q;
	assign standby_o  = standby_q;
	assign busy_o     = busy_q;

endmodule : crc16_ccitt_byte_engine

// ===== verilog/crc16_entry_fifo.sv
// Small synchronous FIFO holding tagged register writes
module crc16_entry_fifo
#(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
)
(
	// Clock and synchronous clear, active low
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	// Filling side
	input  wire logic                     in_valid_i,
	input  wire logic [WIDTH-1:0]         in_data_i,
	output logic                          in_ready_o,
	// Draining side
	output logic                          out_valid_o,
	output logic      [WIDTH-1:0]         out_data_o,
	input  wire logic                     out_ready_i,
	// Fill level
	output logic      [$clog2(DEPTH):0]   level_o
);

	localparam int unsigned PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [0:DEPTH-1];
	logic [PTR_W:0]   wr_ptr_q;
	logic [PTR_W:0]   rd_ptr_q;
	logic             push;
	logic             pop;

	// Full when pointers differ only in the wrap bit
	assign level_o     = wr_ptr_q - rd_ptr_q;
	assign in_ready_o  = (level_o != DEPTH[PTR_W:0]);
	assign out_valid_o = (wr_ptr_q != rd_ptr_q);
	assign out_data_o  = mem_q[rd_ptr_q[PTR_W-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage is not cleared; empty pointers hide stale words
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_q[wr_ptr_q[PTR_W-1:0]] <= in_data_i;
		end
	end

	// Write pointer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			wr_ptr_q <= '0;
		else if (push)
			wr_ptr_q <= wr_ptr_q + 1'b1;
	end

	// Read pointer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rd_ptr_q <= '0;
		else if (pop)
			rd_ptr_q <= rd_ptr_q + 1'b1;
	end

endmodule : crc16_entry_fifo

// ===== verilog/crc16_pkg.sv
// Shared constants and types for the CRC16 byte engine
package crc16_pkg;

	// ------------------------------------------------------------------
	// Widths and depths
	// ------------------------------------------------------------------
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned CRC_W      = 16;
	localparam int unsigned ADDR_W     = 3;
	localparam int unsigned ENTRY_W    = 9;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned LEVEL_W    = 4;

	// ------------------------------------------------------------------
	// Generator polynomial and reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] CRC_POLY      = 16'h1021;
	localparam logic [15:0] CRC_RESET     = 16'h0000;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic        PENDING_RESET = 1'b0;
	localparam logic        DROP_RESET    = 1'b0;
	localparam logic [7:0]  RDATA_RESET   = 8'h00;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [2:0] ADDR_HIGH     = 3'h0;
	localparam logic [2:0] ADDR_LOW      = 3'h1;
	localparam logic [2:0] ADDR_STATUS   = 3'h2;
	localparam logic [2:0] ADDR_COUNT_LO = 3'h3;
	localparam logic [2:0] ADDR_COUNT_HI = 3'h4;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned ST_PENDING   = 0;
	localparam int unsigned ST_BUSY      = 1;
	localparam int unsigned ST_STANDBY   = 2;
	localparam int unsigned ST_DROP      = 3;
	localparam int unsigned ST_LEVEL_LSB = 4;
	localparam int unsigned ENTRY_KIND   = 8;

	// ------------------------------------------------------------------
	// Power state of the engine
	// ------------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ENG_RUN     = 2'b00,
		ENG_STANDBY = 2'b01,
		ENG_OFF     = 2'b10
	} eng_state_t;

endpackage : crc16_pkg
